// File: shared/phy_logic_defines.vh
`ifndef PHY_LOGIC_DEFINES_VH
`define PHY_LOGIC_DEFINES_VH
`define SYM_W 10
`define BYTE_W 8
`define K_COM 8'hbc
`define K_SKP 8'h1c
`define K28_LOW 5'h1c
`define LFSR_SEED 16'hffff
`define LFSR_TAPS 16'h0039
`define COMMA_NEG 10'h0fa
`define COMMA_POS 10'h305
`define PPM_TOL 600
`define PPM_BASE 1000000
`define CODE_6B_K28 6'h0f
`define CODE_4B_A7 4'h7
`endif

// File: design/elastic_ram.v
`timescale 1ns/1ps
`default_nettype none
module elastic_ram #(
   parameter AW = 4,
   parameter DW = 10
) (
   input  wire          clk_sys,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   input  wire          rd_en,
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // No reset: contents are only read after being written
   always @(posedge clk_sys)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      if (rd_en)
         rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// File: design/pcie_phy_logical.v
// Summary of operation
// - Transmit bytes scrambled before 8b/10b encoding
// - Receive bytes descrambled after 8b/10b decoding
// - Scrambler covers data bytes and idle fill
// - Scrambling may be off during training states
// - Byte split into 3b/4b and 5b/6b groups
// - Control flag selects one of twelve specials
// - Ten-bit symbol shifted out serially
// - Special symbols frame packets on both ends
// - DC balanced code; invalid symbols flagged
// - Elastic FIFO between link and local rate
// - Absorb one slip per 1666 symbols
// - FIFO target level follows measured offset
// - Prepared symbols exchanged with link layer
`timescale 1ns/1ps
`default_nettype none
`include "phy_logic_defines.vh"
module pcie_phy_logical #(
   parameter BIT_DIV = 12,
   parameter AW      = 4
) (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire [7:0] tx_data,
   input  wire       tx_k,
   input  wire       tx_valid,
   output reg        tx_ready,
   input  wire       scramble_off,
   input  wire       link_training,
   output reg        tx_serial,
   input  wire       rx_clk,
   input  wire       rx_serial,
   output reg  [7:0] rx_data,
   output reg        rx_k,
   output reg        rx_err,
   output reg        rx_valid,
   output reg        rx_aligned
);
   localparam WIN     = `PPM_BASE / `PPM_TOL;
   localparam SYM_DIV = BIT_DIV * `SYM_W;
   localparam [AW:0] MID = (1 << (AW - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   function [23:0] scr_step;
      input [15:0] lfsr;
      reg   [15:0] l;
      reg   [7:0]  key;
      integer      i;
      begin
         l = lfsr;
         key = 8'h00;
         for (i = 0; i < 8; i = i + 1)
         begin
            key[i] = l[15];
            l = {l[14:0], 1'b0} ^ (l[15] ? `LFSR_TAPS : 16'h0000);
         end
         scr_step = {key, l};
      end
   endfunction

   // Returns {running disparity after, abcdei fghj}
   function [10:0] enc;
      input       k;
      input [7:0] d;
      input       rd;
      reg   [5:0] s6;
      reg   [3:0] s4;
      reg   [4:0] x;
      reg   [2:0] y;
      reg         rd6;
      reg         a7;
      integer     n6;
      integer     n4;
      integer     i;
      begin
         x = d[4:0];
         y = d[7:5];
         case (x)
            5'd0: s6 = 6'h27;
            5'd1: s6 = 6'h1d;
            5'd2: s6 = 6'h2d;
            5'd3: s6 = 6'h31;
            5'd4: s6 = 6'h35;
            5'd5: s6 = 6'h29;
            5'd6: s6 = 6'h19;
            5'd7: s6 = 6'h38;
            5'd8: s6 = 6'h39;
            5'd9: s6 = 6'h25;
            5'd10: s6 = 6'h15;
            5'd11: s6 = 6'h34;
            5'd12: s6 = 6'h0d;
            5'd13: s6 = 6'h2c;
            5'd14: s6 = 6'h1c;
            5'd15: s6 = 6'h17;
            5'd16: s6 = 6'h1b;
            5'd17: s6 = 6'h23;
            5'd18: s6 = 6'h13;
            5'd19: s6 = 6'h32;
            5'd20: s6 = 6'h0b;
            5'd21: s6 = 6'h2a;
            5'd22: s6 = 6'h1a;
            5'd23: s6 = 6'h3a;
            5'd24: s6 = 6'h33;
            5'd25: s6 = 6'h26;
            5'd26: s6 = 6'h16;
            5'd27: s6 = 6'h36;
            5'd28: s6 = 6'h0e;
            5'd29: s6 = 6'h2e;
            5'd30: s6 = 6'h1e;
            default: s6 = 6'h2b;
         endcase
         if (k && x == `K28_LOW)
            s6 = `CODE_6B_K28;
         n6 = 0;
         for (i = 0; i < 6; i = i + 1)
            n6 = n6 + s6[i];
         if (rd && (n6 != 3 || x == 5'd7))
            s6 = ~s6;
         rd6 = (n6 != 3) ? ~rd : rd;
         case (y)
            3'd0: s4 = 4'hb;
            3'd1: s4 = 4'h9;
            3'd2: s4 = 4'h5;
            3'd3: s4 = 4'hc;
            3'd4: s4 = 4'hd;
            3'd5: s4 = 4'ha;
            3'd6: s4 = 4'h6;
            default: s4 = 4'he;
         endcase
         a7 = (y == 3'd7) && (k || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
              (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
         if (a7)
            s4 = `CODE_4B_A7;
         n4 = 0;
         for (i = 0; i < 4; i = i + 1)
            n4 = n4 + s4[i];
         // K28.3 keeps its balanced 1100 when entered at positive disparity
         if ((rd6 && (n4 != 2 || y == 3'd3)) || (k && x == `K28_LOW && rd && n4 == 2 && y != 3'd3))
            s4 = ~s4;
         enc = {(n4 != 2) ? ~rd6 : rd6, s6, s4};
      end
   endfunction

   // Returns {ok, rd after, k, byte}; searches every legal code
   function [10:0] dec;
      input [9:0] sym;
      input       rd;
      reg   [10:0] t;
      reg   [8:0]  c;
      reg          kv;
      integer      i;
      begin
         dec = {1'b0, rd, 9'h000};
         for (i = 0; i < 512; i = i + 1)
         begin
            c = i[8:0];
            kv = !c[8] || c[4:0] == `K28_LOW || (c[7:5] == 3'd7 &&
                 (c[4:0] == 5'd23 || c[4:0] == 5'd27 || c[4:0] == 5'd29 || c[4:0] == 5'd30));
            t = enc(c[8], c[7:0], rd);
            if (kv && t[9:0] == sym)
               dec = {1'b1, t[10], c};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path
   reg  [7:0]  div_cnt;
   reg  [3:0]  bit_idx;
   reg  [8:0]  tx_shift;
   reg         tx_rd;
   reg  [15:0] tx_lfsr;
   wire        bit_en  = (div_cnt == BIT_DIV - 1);
   wire        scr_dis = scramble_off & link_training;
   wire [7:0]  tx_byte = tx_valid ? tx_data : 8'h00;
   wire        tx_kk   = tx_valid & tx_k;
   wire [23:0] tx_scr  = scr_step(tx_lfsr);
   wire [7:0]  tx_enc_in = (tx_kk || scr_dis) ? tx_byte : tx_byte ^ tx_scr[23:16];
   wire [10:0] tx_sym    = enc(tx_kk, tx_enc_in, tx_rd);

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= 8'h00;
         bit_idx <= 4'h0;
         tx_shift <= 9'h000;
         tx_rd <= 1'b0;
         tx_lfsr <= `LFSR_SEED;
         tx_serial <= 1'b0;
         tx_ready <= 1'b0;
      end
      else
      begin
         div_cnt <= bit_en ? 8'h00 : div_cnt + 8'h01;
         tx_ready <= bit_en && bit_idx == 4'h0 && tx_valid;
         if (bit_en)
         begin
            bit_idx <= (bit_idx == 4'h9) ? 4'h0 : bit_idx + 4'h1;
            if (bit_idx == 4'h0)
            begin
               tx_serial <= tx_sym[9];
               tx_shift <= tx_sym[8:0];
               tx_rd <= tx_sym[10];
               if (tx_kk && tx_byte == `K_COM)
                  tx_lfsr <= `LFSR_SEED;
               else if (!(tx_kk && tx_byte == `K_SKP))
                  tx_lfsr <= tx_scr[15:0];
            end
            else
            begin
               tx_serial <= tx_shift[8];
               tx_shift <= {tx_shift[7:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive: sampling, alignment, decode, FIFO write
   reg  [2:0]  clk_sync;
   reg  [1:0]  dat_sync;
   reg  [9:0]  rx_win;
   reg  [3:0]  rx_cnt;
   reg  [9:0]  rx_sym;
   reg         sym_rdy;
   reg         rx_rd;
   reg  [AW:0] wptr;
   reg  [AW:0] rptr;
   reg  [AW:0] target;
   wire        rx_edge = clk_sync[1] & ~clk_sync[2];
   wire [9:0]  nwin    = {rx_win[8:0], dat_sync[1]};
   wire        comma   = (nwin == `COMMA_NEG) || (nwin == `COMMA_POS);
   wire [10:0] dres    = dec(rx_sym, rx_rd);
   wire [AW:0] level   = wptr - rptr;
   wire        is_skp  = dres[8] && dres[7:0] == `K_SKP;
   // drop skip only when above target
   wire        drop    = is_skp && level > target;
   wire        wr_en   = sym_rdy && !drop && level < (MID << 1);

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_sync <= 3'h0;
         dat_sync <= 2'h0;
         rx_win <= 10'h000;
         rx_cnt <= 4'h0;
         rx_sym <= 10'h000;
         sym_rdy <= 1'b0;
         rx_rd <= 1'b0;
         rx_aligned <= 1'b0;
         wptr <= {(AW+1){1'b0}};
      end
      else
      begin
         clk_sync <= {clk_sync[1:0], rx_clk};
         dat_sync <= {dat_sync[0], rx_serial};
         sym_rdy <= 1'b0;
         if (rx_edge)
         begin
            rx_win <= nwin;
            if (comma)
            begin
               rx_aligned <= 1'b1;
               rx_cnt <= 4'h0;
               rx_sym <= nwin;
               sym_rdy <= 1'b1;
               rx_rd <= (nwin == `COMMA_POS);
            end
            else if (rx_aligned)
            begin
               rx_cnt <= (rx_cnt == 4'h9) ? 4'h0 : rx_cnt + 4'h1;
               rx_sym <= nwin;
               sym_rdy <= (rx_cnt == 4'h9);
            end
         end
         // keep disparity only on good codes
         if (sym_rdy && dres[10])
            rx_rd <= dres[9];
         if (wr_en)
            wptr <= wptr + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive: elastic read, adaptive target, descramble
   reg  [11:0] sym_cnt;
   reg  [11:0] win_cnt;
   reg  [11:0] recv_cnt;
   reg         pend;
   reg         ins;
   reg         last_skp;
   reg  [15:0] rx_lfsr;
   wire        sym_en = (sym_cnt == SYM_DIV - 1);
   wire [9:0]  ram_q;
   wire        can_rd = sym_en && level != 0;
   // repeat a skip to cover a slow link
   wire        do_ins = can_rd && last_skp && level < target;
   wire        do_pop = can_rd && !do_ins;
   wire [7:0]  q_byte = ins ? `K_SKP : ram_q[7:0];
   wire        q_k    = ins | ram_q[8];
   wire [23:0] rx_scr = scr_step(rx_lfsr);

   // storage between link and local pace
   elastic_ram #(.AW(AW), .DW(`SYM_W)) u_ram (
      .clk_sys (clk_sys),
      .wr_en   (wr_en),
      .wr_addr (wptr[AW-1:0]),
      .wr_data ({~dres[10], dres[8:0]}),
      .rd_en   (do_pop),
      .rd_addr (rptr[AW-1:0]),
      .rd_data (ram_q)
   );

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sym_cnt <= 12'h000;
         win_cnt <= 12'h000;
         recv_cnt <= 12'h000;
         target <= MID;
         rptr <= {(AW+1){1'b0}};
         pend <= 1'b0;
         ins <= 1'b0;
         last_skp <= 1'b0;
         rx_lfsr <= `LFSR_SEED;
         rx_data <= 8'h00;
         rx_k <= 1'b0;
         rx_err <= 1'b0;
         rx_valid <= 1'b0;
      end
      else
      begin
         sym_cnt <= sym_en ? 12'h000 : sym_cnt + 12'h001;
         if (sym_rdy)
            recv_cnt <= recv_cnt + 12'h001;
         if (sym_en)
         begin
            if (win_cnt == WIN - 1)
            begin
               win_cnt <= 12'h000;
               recv_cnt <= 12'h000;
               if (recv_cnt > WIN)
                  target <= MID - 1'b1;
               else if (recv_cnt < WIN)
                  target <= MID + 1'b1;
               else
                  target <= MID;
            end
            else
               win_cnt <= win_cnt + 12'h001;
         end
         if (do_pop)
            rptr <= rptr + 1'b1;
         pend <= do_pop;
         ins <= do_ins;
         rx_valid <= pend | ins;
         if (pend | ins)
         begin
            rx_k <= q_k;
            rx_err <= ins ? 1'b0 : ram_q[9];
            last_skp <= q_k && q_byte == `K_SKP;
            rx_data <= (q_k || scr_dis) ? q_byte : q_byte ^ rx_scr[23:16];
            if (q_k && q_byte == `K_COM)
               rx_lfsr <= `LFSR_SEED;
            else if (!(q_k && q_byte == `K_SKP))
               rx_lfsr <= rx_scr[15:0];
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/phy_logical_checker.sv
`timescale 1ns/1ps
`default_nettype none
module phy_logical_checker #(
   parameter int BIT_DIV = 12
) (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       tx_ready,
   input wire logic       tx_serial,
   input wire logic [7:0] rx_data,
   input wire logic       rx_k,
   input wire logic       rx_err,
   input wire logic       rx_valid,
   input wire logic       rx_aligned
);
   int   tx_gap;
   int   rx_gap;
   logic tx_seen;
   logic rx_seen;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Cycles since the last strobe; pacing is checked on a grid, not a fixed gap
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_gap  <= 0;
         rx_gap  <= 0;
         tx_seen <= 1'b0;
         rx_seen <= 1'b0;
      end
      else
      begin
         tx_gap  <= tx_ready ? 1 : tx_gap + 1;
         rx_gap  <= rx_valid ? 1 : rx_gap + 1;
         tx_seen <= tx_seen | tx_ready;
         rx_seen <= rx_seen | rx_valid;
      end
   end
   sequence bit_hold;
      $stable(tx_serial) [*8];
   endsequence
   ////////////////////////////////////////
   tx_pulse_a: assert property (tx_ready |=> !tx_ready)
      else $error("tx_ready too long");
   tx_pace_a: assert property (tx_ready && tx_seen |-> tx_gap % (10 * BIT_DIV) == 0)
      else $error("symbol pacing wrong");
   bit_hold_a: assert property (tx_ready |=> bit_hold)
      else $error("first bit too short");
   bit_edge_a: assert property (tx_seen && $changed(tx_serial) |-> tx_gap % BIT_DIV == 0)
      else $error("bit edge off grid");
   rx_pulse_a: assert property (rx_valid |=> !rx_valid)
      else $error("rx_valid too long");
   rx_pace_a: assert property (rx_valid && rx_seen |-> rx_gap % (10 * BIT_DIV) == 0)
      else $error("output pacing wrong");
   rx_hold_a: assert property (!rx_valid |-> $stable({rx_data, rx_k, rx_err}))
      else $error("output moved");
   align_keep_a: assert property (rx_aligned |=> rx_aligned)
      else $error("alignment lost");
   align_first_a: assert property (rx_valid |-> rx_aligned)
      else $error("output before comma");
endmodule
bind pcie_phy_logical phy_logical_checker #(.BIT_DIV(BIT_DIV)) chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .tx_ready(tx_ready), .tx_serial(tx_serial), .rx_data(rx_data),
   .rx_k(rx_k), .rx_err(rx_err), .rx_valid(rx_valid), .rx_aligned(rx_aligned));
`default_nettype wire

// File: tb/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model #(
   parameter int BIT_DIV = 12
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic tx_serial,
   output var  logic rx_clk,
   output var  logic rx_serial
);
   logic q[$];
   int   ph;
   ////////////////////////////////////////
   // framed symbols looped back
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q.delete();
         ph = 0;
      end
      else
      begin
         if (ph == 0)
            q.push_back(tx_serial);
         ph = (ph + 1) % BIT_DIV;
      end
   end
   // Link clock stands still with nothing queued; the lane toggles so no stale level lingers
   initial
   begin
      rx_clk = 1'b0;
      rx_serial = 1'b0;
      #3;
      forever
      begin
         if (q.size() > 0)
         begin
            rx_serial = q.pop_front();
            #62.5 rx_clk = 1'b1;
            #62.5 rx_clk = 1'b0;
         end
         else
         begin
            rx_serial = ~rx_serial;
            #125;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/pcie_phy_logical_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_logic_defines.vh"
module pcie_phy_logical_bench;
   localparam int         BIT_DIV = 12;
   localparam logic [8:0] SKP = {1'b1, `K_SKP};
   logic [7:0] kcode [12] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc, 8'hf7, 8'hfb, 8'hfd, 8'hfe};
   logic       clk_sys = 1'b0;
   logic       rst_n, tx_k, tx_valid, scramble_off, link_training, tx_ready, tx_serial;
   logic       rx_clk, rx_serial, rx_k, rx_err, rx_valid, rx_aligned;
   logic [7:0] tx_data, rx_data;
   logic [8:0] exp_q[$];
   logic [8:0] last, want;
   logic [9:0] sym;
   int         bad_count, n_compared, seed, i, m, r;
   always #5 clk_sys = ~clk_sys;
   pcie_phy_logical #(.BIT_DIV(BIT_DIV)) uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .tx_data(tx_data), .tx_k(tx_k), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .scramble_off(scramble_off), .link_training(link_training), .tx_serial(tx_serial),
      .rx_clk(rx_clk), .rx_serial(rx_serial), .rx_data(rx_data), .rx_k(rx_k), .rx_err(rx_err),
      .rx_valid(rx_valid), .rx_aligned(rx_aligned));
   host_port_model #(.BIT_DIV(BIT_DIV)) far (
      .clk_sys(clk_sys), .rst_n(rst_n), .tx_serial(tx_serial), .rx_clk(rx_clk), .rx_serial(rx_serial));
   ////////////////////////////////////////
   task compare(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Returns before the next load so no idle slips in between bytes
   task send(input logic k, input logic [7:0] d);
      int j;
      tx_k = k;
      tx_data = d;
      tx_valid = 1'b1;
      for (j = 0; j < 400 && tx_ready !== 1'b1; j++)
         @(negedge clk_sys);
      compare(j < 400, "byte not taken"); // handshake
      if (j >= 400)
         end_of_test();
      exp_q.push_back({k, d});
      for (j = 0; j < 10; j++)
      begin
         if (j > 0)
            repeat (BIT_DIV) @(negedge clk_sys);
         sym = {sym[8:0], tx_serial};
      end
   endtask
   task gap;
      tx_valid = 1'b0;
      exp_q.push_back(9'h000);
      repeat (10 * BIT_DIV) @(negedge clk_sys);
   endtask
   ////////////////////////////////////////
   always @(negedge clk_sys)
      if (rx_valid === 1'b1)
      begin
         want = exp_q.size() ? exp_q[0] : 9'h000;
         if (!({rx_k, rx_data} === SKP && last === SKP && want !== SKP))
         begin
            compare({rx_err, rx_k, rx_data} === {1'b0, want}, "rx byte"); // byte order
            if (exp_q.size())
               void'(exp_q.pop_front());
         end
         last = {rx_k, rx_data};
      end
   initial
   begin
      seed = 32'h9754;
      bad_count = 0;
      n_compared = 0;
      rst_n = 1'b0;
      for (m = 0; m < 3; m++)
      begin
         @(negedge clk_sys);
         rst_n = 1'b0;
         tx_k = 1'b1;
         tx_data = `K_COM;
         tx_valid = 1'b1;
         scramble_off = m > 0;
         link_training = m != 1;
         exp_q.delete();
         last = 9'h000;
         repeat (8) @(negedge clk_sys);
         rst_n = 1'b1;
         send(1'b1, `K_COM);
         compare(sym === `COMMA_NEG, "comma symbol"); // comma bits
         send(1'b0, 8'h00);
         compare((sym === 10'h18b) == (m == 2), "scramble mode"); // scramble mode
         for (i = 0; i < 12; i++)
            send(1'b1, kcode[i]); // all specials
         for (i = 0; i < 24; i++)
         begin
            r = $random(seed);
            if (r[4:2] == 0)
               gap(); // idle fill
            send(1'b0, r[7:0]); // random data
         end
         gap();
         for (i = 0; i < 20000 && exp_q.size() > 0; i++)
            @(negedge clk_sys);
         compare(exp_q.size() == 0, "receive stalled"); // no loss
         if (exp_q.size() != 0)
            end_of_test();
      end
      end_of_test();
   end
endmodule
`default_nettype wire
